// file: rtl/ocp_pkg.sv
// Constants, types and register layout for the output compare and PWM channel.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`default_nettype none

package ocp_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int IRQ_W = 2;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PAD = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_PRIM = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_SEC = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_MASK = 5'h14;

    // ==========================================================
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_TSEL_BIT = 3;
    localparam int CTRL_FLT_BIT = 4;
    localparam int CTRL_SIDL_BIT = 13;
    localparam int PAD_TRIS_BIT = 3;
    localparam int IRQ_CMP_BIT = 0;
    localparam int IRQ_FLT_BIT = 1;

    // ==========================================================
    // Reset values
    localparam logic [CNT_W-1:0] RST_CMP = 16'h0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h00000000;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SET = 3'h1,
        MODE_CLR = 3'h2,
        MODE_TGL = 3'h3,
        MODE_ONE = 3'h4,
        MODE_CONT = 3'h5,
        MODE_PWM = 3'h6,
        MODE_PWMF = 3'h7
    } ocp_mode_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] period;
    } ocp_timer_t;

    typedef struct packed {
        logic idle_stop;
        logic timebase_select;
        ocp_mode_t mode_select;
    } ocp_ctrl_t;

    localparam ocp_ctrl_t RST_CTRL = '{idle_stop: 1'b0, timebase_select: 1'b0, mode_select: MODE_OFF};

endpackage : ocp_pkg

`default_nettype wire

// file: rtl/ocp_channel.sv
// Single output compare channel with pulse and PWM modes, Avalon-MM register slave.
// Assumes both timers count and wrap outside this block, synchronous to clock.
//
// Summary of operation
// - Mode 000 disables the channel; output stays low and undriven.
// - Mode 001 starts low and goes high on a primary match.
// - Mode 010 starts high and goes low on a primary match.
// - Mode 011 inverts the output on every primary match.
// - Mode 100 gives one pulse: high on primary, low on secondary match.
// - Mode 101 repeats the pulse every timer period.
// - Mode 110 runs PWM and ignores the fault input.
// - Mode 111 runs PWM and the fault input forces the output low.
// - Fault status sets only in mode 111; a control write with the fault input inactive, or leaving mode 111, clears it.
// - With idle stop set, the channel freezes while the processor idles.
// - Timebase select one picks timer three, zero picks timer two.
// - Tri-state select keeps the pin undriven; internal result stays available.
// - The dedicated fault input pin is the fault source.
// - PWM resolution follows the period value across the full count width.
// - In PWM, secondary is copied to primary only on period match.
// - Duty zero holds low, above period holds high, equal gives one low count.
// - Each secondary match in pulse modes sets the compare interrupt flag.
// - Period lasts period value plus one counts; timer wraps on match.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`default_nettype none

module ocp_channel
    import ocp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    // Time bases
    input wire ocp_timer_t timer2,
    input wire ocp_timer_t timer3,
    // System state and fault
    input wire logic cpu_idle,
    input wire logic fault_input_pin_n,
    // Compare output
    output logic compare_output_pin,
    output logic compare_output_oe,
    output logic compare_module_internal,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // State
    ocp_ctrl_t ctrl_r;
    logic tris_r;
    logic [CNT_W-1:0] primary_r;
    logic [CNT_W-1:0] primary_nxt;
    logic [CNT_W-1:0] secondary_r;
    logic [IRQ_W-1:0] stat_r;
    logic [IRQ_W-1:0] stat_nxt;
    logic [IRQ_W-1:0] mask_r;
    logic out_r;
    logic out_nxt;
    logic done_r;
    logic done_nxt;
    logic fault_r;
    logic fault_nxt;
    logic ack_r;
    logic [DATA_W-1:0] rdata_r;
    logic eq_pri_d_r;
    logic eq_sec_d_r;
    logic eq_per_d_r;

    // ==========================================================
    // Bus decode
    wire logic acc = read | write;
    wire logic wr_go = write & ack_r;
    wire logic rd_go = read & ~ack_r;
    wire logic wr_ctrl = wr_go && (address == OFS_CTRL);
    wire logic wr_pad = wr_go && (address == OFS_PAD);
    wire logic wr_prim = wr_go && (address == OFS_PRIM);
    wire logic wr_sec = wr_go && (address == OFS_SEC);
    wire logic wr_stat = wr_go && (address == OFS_STAT);
    wire logic wr_mask = wr_go && (address == OFS_MASK);
    wire ocp_mode_t new_mode = ocp_mode_t'(writedata[CTRL_MODE_MSB:CTRL_MODE_LSB]);

    assign waitrequest = acc & ~ack_r;
    assign readdata = rdata_r;

    // ==========================================================
    // Time base and match detection
    wire ocp_mode_t mode = ctrl_r.mode_select;
    wire ocp_timer_t tb = ctrl_r.timebase_select ? timer3 : timer2;
    wire logic halted = ctrl_r.idle_stop & cpu_idle;
    wire logic run = ~halted && (mode != MODE_OFF);
    wire logic is_pwm = (mode == MODE_PWM) || (mode == MODE_PWMF);
    wire logic is_pulse = (mode == MODE_ONE) || (mode == MODE_CONT);
    wire logic eq_pri = tb.count == primary_r;
    wire logic eq_sec = tb.count == secondary_r;
    wire logic eq_per = tb.count == tb.period;
    wire logic m_pri = run & eq_pri & ~eq_pri_d_r;
    wire logic m_sec = run & eq_sec & ~eq_sec_d_r;
    wire logic m_per = run & eq_per & ~eq_per_d_r;
    // Full-width compare: duty resolution is set by the period value alone
    wire logic pwm_level = tb.count < primary_r;
    wire logic fault_act = (mode == MODE_PWMF) & ~fault_input_pin_n;
    wire logic cmp_evt = (is_pulse & m_sec) | (is_pwm & m_per) |
        (m_pri & ((mode == MODE_SET) | (mode == MODE_CLR) | (mode == MODE_TGL)));
    wire logic flt_evt = run & fault_act & ~fault_r;
    wire logic [IRQ_W-1:0] evt = {flt_evt, cmp_evt};

    // ==========================================================
    // Output generation
    always_comb begin
        out_nxt = out_r;
        done_nxt = done_r;
        if (wr_ctrl) begin
            out_nxt = (new_mode == MODE_CLR);
            done_nxt = 1'b0;
        end else if (!halted) begin
            unique case (mode)
                MODE_OFF: out_nxt = 1'b0;
                MODE_SET: if (m_pri) out_nxt = 1'b1;
                MODE_CLR: if (m_pri) out_nxt = 1'b0;
                MODE_TGL: if (m_pri) out_nxt = ~out_r;
                MODE_ONE: begin
                    if (!done_r && m_sec) begin
                        out_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end else if (!done_r && m_pri) begin
                        out_nxt = 1'b1;
                    end
                end
                MODE_CONT: begin
                    if (m_sec) begin
                        out_nxt = 1'b0;
                    end else if (m_pri) begin
                        out_nxt = 1'b1;
                    end
                end
                MODE_PWM: out_nxt = pwm_level;
                MODE_PWMF: out_nxt = pwm_level & ~fault_act & ~fault_r;
            endcase
        end
    end

    // ==========================================================
    // Duty buffer, fault status and interrupt status
    always_comb begin
        primary_nxt = primary_r;
        if (is_pwm && m_per) begin
            primary_nxt = secondary_r;
        end else if (wr_prim && !is_pwm) begin
            primary_nxt = writedata[CNT_W-1:0];
        end
    end

    always_comb begin
        fault_nxt = fault_r;
        if (run && fault_act) begin
            fault_nxt = 1'b1;
        end else if (mode != MODE_PWMF) begin
            fault_nxt = 1'b0;
        end else if (wr_ctrl && fault_input_pin_n) begin
            fault_nxt = 1'b0;
        end
    end

    always_comb begin
        stat_nxt = stat_r;
        if (wr_stat) begin
            stat_nxt = stat_r & ~writedata[IRQ_W-1:0];
        end
        stat_nxt = stat_nxt | evt;
    end

    assign irq = |(stat_r & mask_r);
    assign compare_output_pin = out_r;
    assign compare_output_oe = ~tris_r && (mode != MODE_OFF);
    assign compare_module_internal = out_r;

    // ==========================================================
    // Read mux
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (address)
            OFS_CTRL: begin
                rd_mux[CTRL_MODE_MSB:CTRL_MODE_LSB] = mode;
                rd_mux[CTRL_TSEL_BIT] = ctrl_r.timebase_select;
                rd_mux[CTRL_FLT_BIT] = fault_r;
                rd_mux[CTRL_SIDL_BIT] = ctrl_r.idle_stop;
            end
            OFS_PAD: rd_mux[PAD_TRIS_BIT] = tris_r;
            OFS_PRIM: rd_mux[CNT_W-1:0] = primary_r;
            OFS_SEC: rd_mux[CNT_W-1:0] = secondary_r;
            OFS_STAT: rd_mux[IRQ_W-1:0] = stat_r;
            OFS_MASK: rd_mux[IRQ_W-1:0] = mask_r;
            default: rd_mux = '0;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            rdata_r <= RST_RDATA;
        end else begin
            ack_r <= acc & ~ack_r;
            if (rd_go) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r <= RST_CTRL;
            tris_r <= 1'b0;
            secondary_r <= RST_CMP;
            mask_r <= RST_IRQ;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= '{idle_stop: writedata[CTRL_SIDL_BIT],
                    timebase_select: writedata[CTRL_TSEL_BIT], mode_select: new_mode};
            end
            if (wr_pad) tris_r <= writedata[PAD_TRIS_BIT];
            if (wr_sec) secondary_r <= writedata[CNT_W-1:0];
            if (wr_mask) mask_r <= writedata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            primary_r <= RST_CMP;
            stat_r <= RST_IRQ;
            out_r <= 1'b0;
            done_r <= 1'b0;
            fault_r <= 1'b0;
            eq_pri_d_r <= 1'b0;
            eq_sec_d_r <= 1'b0;
            eq_per_d_r <= 1'b0;
        end else begin
            primary_r <= primary_nxt;
            stat_r <= stat_nxt;
            out_r <= out_nxt;
            done_r <= done_nxt;
            fault_r <= fault_nxt;
            eq_pri_d_r <= eq_pri;
            eq_sec_d_r <= eq_sec;
            eq_per_d_r <= eq_per;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    wire logic quiet = ~wr_ctrl & ~halted;

    sequence seq_pulse_end;
        (mode == MODE_ONE) && m_sec && !done_r && quiet;
    endsequence

    sequence seq_fault_hit;
        run && fault_act;
    endsequence

    a_off_pin_low: assert property ((mode == MODE_OFF) && !wr_ctrl |=> !out_r && !compare_output_oe)
        else $error("output active while channel disabled");
    a_set_on_match: assert property ((mode == MODE_SET) && m_pri && quiet |=> out_r)
        else $error("set mode did not raise output");
    a_clear_on_match: assert property ((mode == MODE_CLR) && m_pri && quiet |=> !out_r)
        else $error("clear mode did not lower output");
    a_toggle_flip: assert property ((mode == MODE_TGL) && m_pri && quiet |=> out_r != $past(out_r))
        else $error("toggle mode did not invert output");
    a_single_done: assert property (seq_pulse_end |=> done_r && !out_r)
        else $error("single pulse did not end");
    a_cont_rise: assert property ((mode == MODE_CONT) && m_pri && !m_sec && quiet |=> out_r)
        else $error("continuous pulse did not rise");
    a_pwm_level: assert property (is_pwm && !fault_r && !fault_act && quiet
        |=> out_r == ($past(tb.count) < $past(primary_r)))
        else $error("pwm output level wrong");
    a_fault_hold: assert property (seq_fault_hit and quiet |=> fault_r && !out_r)
        else $error("fault did not force output low");
    a_duty_copy: assert property (is_pwm && m_per |=> primary_r == $past(secondary_r))
        else $error("duty not reloaded on period match");
    a_halt_freeze: assert property (halted && !wr_ctrl |=> $stable(out_r))
        else $error("output moved while halted");
    a_tris_oe: assert property (tris_r |-> !compare_output_oe)
        else $error("pin driven while tri-stated");
    a_irq_flag: assert property (is_pulse && m_sec |=> stat_r[IRQ_CMP_BIT])
        else $error("compare flag not set on secondary match");
    a_bus_answer: assert property (acc && waitrequest |=> !waitrequest)
        else $error("bus answer late");

endmodule : ocp_channel

`default_nettype wire

// file: sim/ocp_load_model.sv
// Far-side model: free-running time bases and the pad level seen by the load.
// Assumes the channel samples both counts on the rising edge of clock.
`default_nettype none

module ocp_load_model
    import ocp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Period values
    input wire logic [CNT_W-1:0] per2,
    input wire logic [CNT_W-1:0] per3,
    // Time bases
    output var ocp_timer_t timer2,
    output var ocp_timer_t timer3,
    // Pad
    input wire logic pin,
    input wire logic oe,
    output logic pad
);
    // ==========================================================
    // Timers and pad memory
    logic [CNT_W-1:0] cnt2_r;
    logic [CNT_W-1:0] cnt3_r;
    logic last_r;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt2_r <= 16'h0000;
            cnt3_r <= 16'h0000;
            last_r <= 1'h0;
        end else begin
            cnt2_r <= (cnt2_r == per2) ? 16'h0000 : cnt2_r + 16'h0001;
            cnt3_r <= (cnt3_r == per3) ? 16'h0000 : cnt3_r + 16'h0001;
            last_r <= oe ? pin : last_r;
        end
    end

    assign timer2 = '{count: cnt2_r, period: per2};
    assign timer3 = '{count: cnt3_r, period: per3};
    // Released pad shows the inverse of its last driven level
    assign pad = oe ? pin : ~last_r;

endmodule : ocp_load_model

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the output compare channel.
// Assumes the load model supplies both time bases.
`default_nettype none

module tb
    import ocp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic clock = 1'h0, sys_rst = 1'h1, read = 1'h0, write = 1'h0, cpu_idle = 1'h0, fault_n = 1'h1;
    logic [ADDR_W-1:0] address = 5'h00;
    logic [DATA_W-1:0] writedata = 32'h0, readdata, q;
    logic [CNT_W-1:0] per2 = 16'h000F, per3 = 16'h0009, prev;
    ocp_timer_t timer2, timer3;
    logic waitrequest, pin, oe, internal, irq, pad;
    int num_errors = 0, cmp_count = 0, cyc = 0;

    ocp_channel u_dut (.clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .timer2(timer2),
        .timer3(timer3), .cpu_idle(cpu_idle), .fault_input_pin_n(fault_n), .compare_output_pin(pin),
        .compare_output_oe(oe), .compare_module_internal(internal), .irq(irq));
    ocp_load_model u_load (.clock(clock), .sys_rst(sys_rst), .per2(per2), .per3(per3), .timer2(timer2),
        .timer3(timer3), .pin(pin), .oe(oe), .pad(pad));

    initial begin
        forever #4 clock = ~clock;
    end

    // ==========================================================
    // Helpers
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] got);
        cmp_count++;
        if (got !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask : check

    task automatic xfer(input logic wr_en, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        address <= a;
        writedata <= d;
        write <= wr_en;
        read <= !wr_en;
        @(posedge clock);
        while (waitrequest !== 1'h0) begin
            @(posedge clock);
        end
        q = readdata;
        write <= 1'h0;
        read <= 1'h0;
        @(posedge clock);
    endtask : xfer

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xfer(1'h1, a, d);
    endtask : wr

    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        xfer(1'h0, a, 32'h0);
        check(what, e, q);
    endtask : rd

    task automatic at(input logic s, input logic [CNT_W-1:0] v);
        int n;
        n = 0;
        @(posedge clock);
        while ((s ? timer3.count : timer2.count) !== v && n < 2000) begin
            n++;
            @(posedge clock);
        end
    endtask : at

    task automatic look(input string what, input logic e);
        @(negedge clock);
        check(what, e, internal);
        if (oe === 1'h1) check({what, " pad"}, e, pad);
        @(posedge clock);
    endtask : look

    task automatic irq_is(input logic e);
        @(negedge clock);
        check("irq", e, irq);
        @(posedge clock);
    endtask : irq_is

    task automatic hi(input string what, input int p, input int e);
        int n;
        n = 0;
        repeat (p + 1) begin
            @(negedge clock);
            if (internal === 1'h1) n++;
        end
        check(what, e, n);
        @(posedge clock);
    endtask : hi

    // ==========================================================
    // Scenarios
    task automatic s_off();
        for (int a = 0; a < 28; a += 4) rd("reset value", 5'(a), 32'h0);
        wr(OFS_PRIM, 32'h5);
        at(1'h0, 16'h0005);
        look("off", 1'h0);
        check("oe off", 1'h0, oe);
        rd("status off", OFS_STAT, 32'h0);
    endtask : s_off

    task automatic s_edges();
        for (int m = 1; m < 4; m++) begin
            at(1'h0, 16'h0000);
            wr(OFS_CTRL, 32'(m));
            at(1'h0, 16'h0004);
            look("init", m == 2);
            look("match", m != 2);
        end
        at(1'h0, 16'h0005);
        look("toggle back", 1'h0);
    endtask : s_edges

    task automatic s_pulse();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_STAT, 32'h3);
        wr(OFS_SEC, 32'h9);
        wr(OFS_PRIM, 32'h4);
        wr(OFS_MASK, 32'h1);
        at(1'h0, 16'h0000);
        wr(OFS_CTRL, 32'h4);
        at(1'h0, 16'h0004);
        look("one rise", 1'h1);
        at(1'h0, 16'h0009);
        look("one fall", 1'h0);
        irq_is(1'h1);
        at(1'h0, 16'h0004);
        look("one only", 1'h0);
        rd("status", OFS_STAT, 32'h1);
        wr(OFS_MASK, 32'h0);
        irq_is(1'h0);
        wr(OFS_MASK, 32'h1);
        irq_is(1'h1);
        wr(OFS_STAT, 32'h1);
        irq_is(1'h0);
        at(1'h0, 16'h0000);
        wr(OFS_CTRL, 32'h5);
        repeat (2) begin
            at(1'h0, 16'h0004);
            look("cont rise", 1'h1);
            at(1'h0, 16'h0009);
            look("cont fall", 1'h0);
        end
    endtask : s_pulse

    task automatic s_pwm();
        logic [CNT_W-1:0] d [4] = '{16'h0000, 16'h0007, 16'h000F, 16'h0014};
        int e [4] = '{0, 7, 15, 16};
        wr(OFS_PRIM, 32'h4);
        wr(OFS_SEC, 32'h4);
        wr(OFS_CTRL, 32'h6);
        wr(OFS_PRIM, 32'hC);
        rd("primary read only", OFS_PRIM, 32'h4);
        prev = 16'h0004;
        foreach (d[i]) begin
            at(1'h0, 16'h0000);
            wr(OFS_SEC, 32'(d[i]));
            rd("primary held", OFS_PRIM, 32'(prev));
            at(1'h0, 16'h0001);
            hi("duty", 15, e[i]);
            prev = d[i];
        end
        at(1'h0, 16'h0000);
        per2 <= 16'h03FF;
        wr(OFS_SEC, 32'h200);
        at(1'h0, 16'h03FF);
        at(1'h0, 16'h0001);
        hi("ten bit duty", 1023, 512);
        at(1'h0, 16'h0000);
        per2 <= 16'h000F;
        fault_n <= 1'h0;
        hi("fault ignored", 15, 16);
        rd("no fault status", OFS_CTRL, 32'h6);
        wr(OFS_CTRL, 32'h7);
        hi("fault stop", 15, 0);
        wr(OFS_CTRL, 32'h7);
        rd("fault status", OFS_CTRL, 32'h17);
        rd("fault irq bit", OFS_STAT, 32'h3);
        fault_n <= 1'h1;
        wr(OFS_CTRL, 32'h7);
        rd("fault cleared", OFS_CTRL, 32'h7);
        hi("fault gone", 15, 16);
        wr(OFS_CTRL, 32'h0);
    endtask : s_pwm

    task automatic s_misc();
        wr(OFS_PRIM, 32'hC);
        at(1'h0, 16'h0000);
        wr(OFS_CTRL, 32'h9);
        at(1'h0, 16'h000C);
        look("timer two unused", 1'h0);
        wr(OFS_PRIM, 32'h7);
        at(1'h1, 16'h0007);
        look("timer three match", 1'h1);
        wr(OFS_PAD, 32'h8);
        rd("pad", OFS_PAD, 32'h8);
        wr(OFS_PRIM, 32'h5);
        at(1'h0, 16'h0000);
        wr(OFS_CTRL, 32'h3);
        at(1'h0, 16'h0005);
        look("internal trigger", 1'h1);
        check("oe tristate", 1'h0, oe);
        wr(OFS_PAD, 32'h0);
        at(1'h0, 16'h0005);
        look("driven again", 1'h0);
        check("oe driven", 1'h1, oe);
        for (int s = 1; s >= 0; s--) begin
            at(1'h0, 16'h0000);
            cpu_idle <= 1'h1;
            wr(OFS_CTRL, 32'((s << 13) | 1));
            at(1'h0, 16'h0005);
            look("idle", s == 0);
            cpu_idle <= 1'h0;
        end
    endtask : s_misc

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        s_off();
        s_edges();
        s_pulse();
        s_pwm();
        s_misc();
        print_verdict();
    end

endmodule : tb

`default_nettype wire
